// ===== design/e3_tx_consts.svh
`ifndef E3_TX_CONSTS_SVH
`define E3_TX_CONSTS_SVH

// register indices; byte address is four times the index
`define LINE_IO_CONTROL_IDX 8'h01
`define ENCODER_STATUS_IDX 8'h02
`define LINE_IO_CONTROL_ADDR 8'h04
`define ENCODER_STATUS_ADDR 8'h08

// line_io_control layout and reset value
`define LINE_IO_CONTROL_RESET 8'hA0
`define LINE_IO_CONTROL_WR_MASK 8'hBF
`define RAIL_MODE_BIT 3
`define CODE_SELECT_BIT 4

// encoder_status layout
`define STAT_LAST_NEG_BIT 0
`define STAT_PARITY_BIT 1
`define STAT_ZRUN_LSB 2
`define STAT_UNIPOLAR_BIT 4
`define STAT_AMI_BIT 5
`define STAT_VCOUNT_LSB 8

// timing of the line clock
`define SYS_CLK_PERIOD_NS 10
`define LINE_BIT_PERIOD_NS 160
`define LINE_BIT_CYCLES (`LINE_BIT_PERIOD_NS / `SYS_CLK_PERIOD_NS)
`define LINE_HALF_CYCLES (`LINE_BIT_CYCLES / 2)

// zero substitution
`define HDB3_RUN_LEN 4
`define HDB3_DELAY 4

`endif

// ===== design/e3_tx_pkg.sv
package e3_tx_pkg;

   // symbol held in the substitution delay line
   typedef enum logic [1:0] {
      sym_zero,
      sym_one,
      sym_b,
      sym_v
   } sym_t;

   // pair of rail requests toward the line interface unit
   typedef struct packed {
      logic pos;
      logic neg;
   } rails_t;

endpackage

// ===== design/e3_tx_line_code_encoder.sv
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`include "e3_tx_consts.svh"

// How it works
// - control bit 3 at index 0x01 picks output: 0 dual-rail bipolar, 1 single-rail.
// - after reset the rail bit is clear, so bipolar dual-rail mode is active.
// - the rail mode also goes to the receive side decoder.
// - in AMI each mark takes the polarity opposite to the previous mark.
// - ones are positive or negative pulses; zero means no pulse on either rail.
// - last mark polarity is remembered across any length of zero run.
// - in HDB3 every run of four zeros becomes 000V or B00V.
// - B follows normal alternation; V repeats the polarity of the preceding pulse.
// - choose 000V or B00V so the pulses (ones and B) between two V pulses are odd.
// - control bit 4 at index 0x01 picks code: 0 HDB3, 1 AMI.
// - the code choice also goes to the receive side decoder.
// - in unipolar mode the code bit has no effect on the output.
// - unipolar sends NRZ data on positive rail, frame start on negative rail.
// - bipolar asserts one rail per mark and never both in one bit.
// - the block drives the line clock that the line interface uses to sample rails.
module e3_tx_line_code_encoder (
   input wire logic clk_sys,
   input wire logic rst_b,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // framer side, same clock
   input wire logic tx_data,
   input wire logic tx_frame_start,
   output logic tx_bit_take,
   // line interface unit side
   output logic tx_positive_rail,
   output logic tx_negative_rail,
   output logic line_side_tx_clock,
   // receive decoder configuration
   output logic rx_rail_unipolar,
   output logic rx_code_ami
);

   //--------------------------------------------------------------
   // declarations
   //--------------------------------------------------------------
   localparam logic [4:0] BIT_LAST = 5'(`LINE_BIT_CYCLES - 1);
   localparam logic [4:0] HALF_MARK = 5'(`LINE_HALF_CYCLES);
   localparam logic [1:0] ZRUN_FULL = 2'(`HDB3_RUN_LEN - 1);

   logic [7:0] line_io_control_r;
   logic [4:0] div_cnt_r;
   logic tick_r;
   logic line_clk_r;
   logic [31:0] prdata_r;
   logic pready_r;
   logic pslverr_r;
   e3_tx_pkg::sym_t pipe_r [`HDB3_DELAY];
   e3_tx_pkg::sym_t pipe_nxt [`HDB3_DELAY];
   logic [1:0] zrun_r;
   logic [1:0] zrun_nxt;
   logic parity_r;
   logic parity_nxt;
   logic last_neg_r;
   logic last_neg_nxt;
   logic [7:0] vcount_r;
   e3_tx_pkg::rails_t rails_r;
   e3_tx_pkg::rails_t rails_nxt;
   logic rx_unipolar_r;
   logic rx_ami_r;

   logic unipolar;
   logic ami;
   logic hdb3;
   logic setup_phase;
   logic access_done;
   logic sub_now;
   logic par_after;
   logic out_mark;
   logic out_viol;
   logic pol_neg;
   e3_tx_pkg::sym_t in_sym;
   e3_tx_pkg::sym_t out_sym;
   logic [31:0] rd_val;
   logic rd_err;

   assign unipolar = line_io_control_r[`RAIL_MODE_BIT];
   assign ami = line_io_control_r[`CODE_SELECT_BIT];
   assign hdb3 = !unipolar && !ami;

   //--------------------------------------------------------------
   // apb register access
   //--------------------------------------------------------------
   assign setup_phase = psel && !penable;
   assign access_done = psel && penable && pready_r;

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr[1:0] != 2'h0) begin
         rd_err = 1'b1;
      end else if (paddr == `LINE_IO_CONTROL_ADDR) begin
         rd_val[7:0] = line_io_control_r & `LINE_IO_CONTROL_WR_MASK;
      end else if (paddr == `ENCODER_STATUS_ADDR) begin
         rd_val[`STAT_LAST_NEG_BIT] = last_neg_r;
         rd_val[`STAT_PARITY_BIT] = parity_r;
         rd_val[`STAT_ZRUN_LSB +: 2] = zrun_r;
         rd_val[`STAT_UNIPOLAR_BIT] = unipolar;
         rd_val[`STAT_AMI_BIT] = ami;
         rd_val[`STAT_VCOUNT_LSB +: 8] = vcount_r;
      end else begin
         rd_err = 1'b1;
      end
   end

   // no wait state: answer is prepared in the setup cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pready_r <= 1'b0;
      end else if (setup_phase) begin
         pready_r <= 1'b1;
      end else begin
         pready_r <= 1'b0;
      end
   end

   // read data stands only in the access cycle
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         prdata_r <= 32'h0000_0000;
      end else if (setup_phase) begin
         prdata_r <= pwrite ? 32'h0000_0000 : rd_val;
      end else begin
         prdata_r <= 32'h0000_0000;
      end
   end

   // unmapped or misaligned address answers with an error
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         pslverr_r <= 1'b0;
      end else if (setup_phase) begin
         pslverr_r <= rd_err;
      end else begin
         pslverr_r <= 1'b0;
      end
   end

   // control register; bit 6 is read-only and stays zero
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         line_io_control_r <= `LINE_IO_CONTROL_RESET;
      end else if (access_done && pwrite && pstrb[0] && !pslverr_r
                   && paddr == `LINE_IO_CONTROL_ADDR) begin
         line_io_control_r <= pwdata[7:0] & `LINE_IO_CONTROL_WR_MASK;
      end
   end

   //--------------------------------------------------------------
   // line clock divider
   //--------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         div_cnt_r <= 5'h00;
      end else begin
         div_cnt_r <= (div_cnt_r == BIT_LAST) ? 5'h00 : div_cnt_r + 5'h01;
      end
   end

   // one-cycle enable in the first cycle of each line bit
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         tick_r <= 1'b0;
      end else begin
         tick_r <= (div_cnt_r == BIT_LAST);
      end
   end

   // rises with each new bit on the rails, falls mid bit
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         line_clk_r <= 1'b0;
      end else if (tick_r) begin
         line_clk_r <= 1'b1;
      end else if (div_cnt_r == HALF_MARK) begin
         line_clk_r <= 1'b0;
      end
   end

   //--------------------------------------------------------------
   // zero substitution and polarity
   //--------------------------------------------------------------
   assign in_sym = tx_data ? e3_tx_pkg::sym_one : e3_tx_pkg::sym_zero;
   // hdb3 reads the far end of the delay line, ami the live bit
   assign out_sym = hdb3 ? pipe_r[`HDB3_DELAY - 1] : in_sym;
   assign out_mark = (out_sym == e3_tx_pkg::sym_one) || (out_sym == e3_tx_pkg::sym_b);
   assign out_viol = (out_sym == e3_tx_pkg::sym_v);
   // B keeps alternation, V repeats the last pulse polarity
   assign pol_neg = out_viol ? last_neg_r : !last_neg_r;

   // parity of pulses (ones and B) since the last V, once the current bit is out
   assign par_after = out_viol ? 1'b0 : (parity_r ^ out_mark);
   assign sub_now = hdb3 && !tx_data && (zrun_r == ZRUN_FULL);

   always_comb begin
      for (int i = 1; i < `HDB3_DELAY; i++) begin
         pipe_nxt[i] = pipe_r[i - 1];
      end
      pipe_nxt[0] = in_sym;
      if (sub_now) begin
         pipe_nxt[0] = e3_tx_pkg::sym_v;
         // odd count so far gives 000V, even gives B00V
         if (!par_after) begin
            pipe_nxt[`HDB3_DELAY - 1] = e3_tx_pkg::sym_b;
         end
      end
      if (!hdb3) begin
         for (int i = 0; i < `HDB3_DELAY; i++) begin
            pipe_nxt[i] = e3_tx_pkg::sym_zero;
         end
      end
   end

   always_comb begin
      zrun_nxt = zrun_r + 2'h1;
      if (tx_data || zrun_r == ZRUN_FULL) begin
         zrun_nxt = 2'h0;
      end
      parity_nxt = hdb3 ? par_after : 1'b0;
      last_neg_nxt = last_neg_r;
      if (!unipolar && (out_mark || out_viol)) begin
         last_neg_nxt = pol_neg;
      end
   end

   always_comb begin
      rails_nxt.pos = 1'b0;
      rails_nxt.neg = 1'b0;
      if (unipolar) begin
         rails_nxt.pos = tx_data;
         rails_nxt.neg = tx_frame_start;
      end else if (out_mark || out_viol) begin
         // exactly one rail per pulse, none for a zero
         rails_nxt.pos = !pol_neg;
         rails_nxt.neg = pol_neg;
      end
   end

   //--------------------------------------------------------------
   // bit state, advanced once per line bit
   //--------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         for (int i = 0; i < `HDB3_DELAY; i++) begin
            pipe_r[i] <= e3_tx_pkg::sym_zero;
         end
      end else if (tick_r) begin
         pipe_r <= pipe_nxt;
      end
   end

   // length of the current input zero run
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         zrun_r <= 2'h0;
      end else if (tick_r) begin
         zrun_r <= zrun_nxt;
      end
   end

   // odd or even count of pulses since the last violation
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         parity_r <= 1'b0;
      end else if (tick_r) begin
         parity_r <= parity_nxt;
      end
   end

   // polarity of the last pulse sent; reset makes the first mark positive
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         last_neg_r <= 1'b1;
      end else if (tick_r) begin
         last_neg_r <= last_neg_nxt;
      end
   end

   // wrapping count of violation pulses sent
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         vcount_r <= 8'h00;
      end else if (tick_r && hdb3 && out_viol) begin
         vcount_r <= vcount_r + 8'h01;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rails_r <= '0;
      end else if (tick_r) begin
         rails_r <= rails_nxt;
      end
   end

   //--------------------------------------------------------------
   // receive side configuration
   //--------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rx_unipolar_r <= 1'b0;
      end else begin
         rx_unipolar_r <= unipolar;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rx_ami_r <= 1'b0;
      end else begin
         rx_ami_r <= ami;
      end
   end

   //--------------------------------------------------------------
   // outputs
   //--------------------------------------------------------------
   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign tx_bit_take = tick_r;
   assign tx_positive_rail = rails_r.pos;
   assign tx_negative_rail = rails_r.neg;
   assign line_side_tx_clock = line_clk_r;
   assign rx_rail_unipolar = rx_unipolar_r;
   assign rx_code_ami = rx_ami_r;

endmodule

// ===== dv/e3_liu_model.sv
`timescale 1ns/1ps
// ----
// line interface unit
// ----
module e3_liu_model (
   input wire logic clk_sys,
   input wire logic line_side_tx_clock,
   input wire logic tx_positive_rail,
   input wire logic tx_negative_rail,
   output e3_tx_pkg::rails_t sym,
   output logic sym_vld
);
   logic clk_d_r;
   // samples both rails at the falling edge of the line clock, mid bit
   always_ff @(posedge clk_sys) begin
      clk_d_r <= line_side_tx_clock;
      sym_vld <= clk_d_r && !line_side_tx_clock;
      sym <= {tx_positive_rail, tx_negative_rail};
   end
endmodule

// ===== dv/e3_tx_line_code_encoder_asserts.sv
`timescale 1ns/1ps
`include "e3_tx_consts.svh"
// ----
// port checks
// ----
module e3_tx_line_code_encoder_asserts (
   input wire logic clk_sys,
   input wire logic rst_b,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_data,
   input wire logic tx_frame_start,
   input wire logic tx_bit_take,
   input wire logic tx_positive_rail,
   input wire logic tx_negative_rail,
   input wire logic line_side_tx_clock,
   input wire logic rx_rail_unipolar,
   input wire logic rx_code_ami
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   logic wr;
   logic [1:0] cfg_r;
   logic rail_uni_r;
   assign wr = psel && penable && pready && pwrite && pstrb[0]
      && paddr == `LINE_IO_CONTROL_ADDR;
   // shadow of the two mode bits
   always_ff @(posedge clk_sys) begin
      if (!rst_b) cfg_r <= 2'b00;
      else if (wr) cfg_r <= pwdata[4:3];
   end
   // rail mode in force when the rails were last loaded
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rail_uni_r <= 1'b0;
      end else if (tx_bit_take) begin
         rail_uni_r <= cfg_r[0];
      end
   end
   AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
      else $error("no access answer");
   AST_BAD_ADDR: assert property (psel && !penable && paddr != `LINE_IO_CONTROL_ADDR
      && paddr != `ENCODER_STATUS_ADDR |=> pslverr) else $error("no error");
   AST_RX_MODE: assert property (!wr && !$past(wr) |-> rx_rail_unipolar == cfg_r[0])
      else $error("rx rail mode");
   AST_RX_CODE: assert property (!wr && !$past(wr) |-> rx_code_ami == cfg_r[1])
      else $error("rx code");
   AST_ONE_RAIL: assert property (tx_positive_rail && tx_negative_rail |-> rail_uni_r)
      else $error("both rails");
   AST_TAKE_PERIOD: assert property (tx_bit_take |-> ##16 tx_bit_take)
      else $error("bit period");
   AST_RAIL_MOVE: assert property ($changed({tx_positive_rail, tx_negative_rail})
      |-> $past(tx_bit_take)) else $error("rails off tick");
   AST_CLK_SHAPE: assert property ($rose(line_side_tx_clock) |-> $past(tx_bit_take)
      ##0 line_side_tx_clock [*8] ##1 !line_side_tx_clock) else $error("line clock");
   AST_UNI_NRZ: assert property ($past(tx_bit_take) && rx_rail_unipolar
      && $past(rx_rail_unipolar) |-> tx_positive_rail == $past(tx_data)
      && tx_negative_rail == $past(tx_frame_start)) else $error("unipolar rails");
endmodule

bind e3_tx_line_code_encoder e3_tx_line_code_encoder_asserts
   e3_tx_line_code_encoder_asserts_inst (
   .clk_sys(clk_sys),
   .rst_b(rst_b),
   .psel(psel),
   .penable(penable),
   .pwrite(pwrite),
   .paddr(paddr),
   .pwdata(pwdata),
   .pstrb(pstrb),
   .pready(pready),
   .pslverr(pslverr),
   .tx_data(tx_data),
   .tx_frame_start(tx_frame_start),
   .tx_bit_take(tx_bit_take),
   .tx_positive_rail(tx_positive_rail),
   .tx_negative_rail(tx_negative_rail),
   .line_side_tx_clock(line_side_tx_clock),
   .rx_rail_unipolar(rx_rail_unipolar),
   .rx_code_ami(rx_code_ami)
);

// ===== dv/e3_tx_line_code_encoder_tb.sv
`timescale 1ns/1ps
`include "e3_tx_consts.svh"
// ----
// bench
// ----
module e3_tx_line_code_encoder_tb;
   logic clk_sys = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic tx_data = 1'b0, tx_frame_start = 1'b0, err;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, tx_bit_take, tx_positive_rail, tx_negative_rail;
   logic line_side_tx_clock, rx_rail_unipolar, rx_code_ami, sym_vld;
   e3_tx_pkg::rails_t sym, q[$];
   int miscompares = 0, tests_run = 0, cyc = 0;
   e3_tx_line_code_encoder e3_tx_line_code_encoder_inst (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .tx_data(tx_data),
      .tx_frame_start(tx_frame_start),
      .tx_bit_take(tx_bit_take),
      .tx_positive_rail(tx_positive_rail),
      .tx_negative_rail(tx_negative_rail),
      .line_side_tx_clock(line_side_tx_clock),
      .rx_rail_unipolar(rx_rail_unipolar),
      .rx_code_ami(rx_code_ami)
   );
   e3_liu_model e3_liu_model_inst (
      .clk_sys(clk_sys),
      .line_side_tx_clock(line_side_tx_clock),
      .tx_positive_rail(tx_positive_rail),
      .tx_negative_rail(tx_negative_rail),
      .sym(sym),
      .sym_vld(sym_vld)
   );
   always #5 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc++;
      if (sym_vld === 1'b1) q.push_back(sym);
      if (cyc == 5000) begin
         miscompares++;
         $display("CHECK FAILED %0t timeout", $time);
         results();
      end
   end
   task automatic chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rst();
      rst_b <= 1'b0;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
   endtask
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      // wait for the answer; only the bench timeout ends a hang
      do begin
         @(posedge clk_sys);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // feeds bits lsb first, then checks rail pairs after skipping skip symbols
   task automatic run(input logic [31:0] d, f, p, m, input int n, skip);
      int w;
      w = 0;
      tx_data <= d[0];
      tx_frame_start <= f[0];
      for (int i = 1; i <= n; i++) begin
         @(posedge clk_sys iff tx_bit_take === 1'b1);
         if (i == 1) q.delete();
         tx_data <= d[i];
         tx_frame_start <= f[i];
      end
      while (q.size() < skip + n && w < 400) begin
         @(posedge clk_sys);
         w++;
      end
      chk(32'(q.size() >= skip + n), 32'h1);
      for (int i = 0; i < n; i++) chk(32'(q[skip + i]), 32'({p[i], m[i]}));
   endtask
   task automatic t_regs();
      rst();
      apb(1'b0, `LINE_IO_CONTROL_ADDR, 32'h0);
      chk(rd, 32'h000000A0);
      apb(1'b0, `ENCODER_STATUS_ADDR, 32'h0);
      chk(rd, 32'h00000001);
      apb(1'b1, `LINE_IO_CONTROL_ADDR, 32'hFFFFFFFF);
      apb(1'b0, `ENCODER_STATUS_ADDR, 32'h0);
      chk(rd, 32'h00000031);
      apb(1'b0, `LINE_IO_CONTROL_ADDR, 32'h0);
      chk(rd, 32'h000000BF);
      chk(32'({rx_rail_unipolar, rx_code_ami}), 32'h3);
      apb(1'b0, 8'h0C, 32'h0);
      chk(32'(err), 32'h1);
      $display("test regs done");
   endtask
   task automatic t_ami();
      rst();
      apb(1'b1, `LINE_IO_CONTROL_ADDR, 32'h000000B0);
      run(32'h000000C1, 32'h0, 32'h00000081, 32'h00000040, 8, 0);
      $display("test ami done");
   endtask
   task automatic t_hdb3();
      rst();
      run(32'h00004021, 32'h0, 32'h00002411, 32'h00004220, 15, 4);
      $display("test hdb3 done");
   endtask
   task automatic t_uni();
      for (int c = 0; c < 2; c++) begin
         rst();
         apb(1'b1, `LINE_IO_CONTROL_ADDR, c ? 32'h000000B8 : 32'h000000A8);
         run(32'h00004021, 32'h00000201, 32'h00004021, 32'h00000201, 15, 0);
      end
      $display("test unipolar done");
   endtask
   task automatic results();
      $display("checks %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      t_regs();
      t_ami();
      t_hdb3();
      t_uni();
      results();
   end
endmodule
